// File: hdl/mii_port_defs.vh
// Constants for the MII port block
// Assumes a 50 MHz ref_clk; link clocks are sampled, not used as clocks
// Behaviour
// - Transmit enable changes only on a rising edge of the PHY transmit clock.
// - The four transmit data lines change only on a transmit clock rising edge, one nibble per period.
// - Every management data bit in either direction is referenced to the rising management clock edge; the block ties neither mdio_out nor mgmt_data_in to mdc.
// - The management clock pin follows bit zero of the management control word, with no clock generation.
// - The management data pin carries serial frames both ways between controller and PHYs.
`ifndef MII_PORT_DEFS_VH
`define MII_PORT_DEFS_VH

// ----------------------------------------
// Management control word
// ----------------------------------------
`define MGMT_CLK_BIT     0
`define MGMT_OUT_BIT     1
`define MGMT_DIR_BIT     2
`define MGMT_CTRL_RESET  3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define MDC_MAX_KHZ      2500
`define SYNC_STAGES      2

`endif

// File: hdl/pin_sync.v
// Two-flop synchroniser bank for pins from outside the ref_clk domain
// Assumes inputs are asynchronous to ref_clk
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 1
) (
	input  wire             ref_clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] pin,
	output reg  [WIDTH-1:0] pin_sync_q
);
	reg [WIDTH-1:0] stage1;

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1     <= {WIDTH{1'b0}};
			pin_sync_q <= {WIDTH{1'b0}};
		end else begin
			stage1     <= pin;
			pin_sync_q <= stage1;
		end
	end
endmodule // pin_sync

// File: hdl/mii_port.v
// MII port: nibble transmit and receive paths, carrier and collision, management pins
// Assumes TX_CLK and RX_CLK are free running and slow enough that a half period spans
// at least four ref_clk cycles, since every link edge is found by sampling
// Assumes the MAC holds tx_byte stable until tx_byte_ready pulses
// Assumes software paces the management clock through mgmt_ctrl
`timescale 1ns/1ps
`include "mii_port_defs.vh"
module mii_port (
	input  wire       ref_clk,
	input  wire       rst_n,
	// MAC transmit side
	input  wire [7:0] tx_byte,
	input  wire       tx_byte_valid,
	output reg        tx_byte_ready,
	// MAC receive side
	output reg  [7:0] rx_byte,
	output reg        rx_byte_valid,
	output reg        rx_frame_active,
	output reg        rx_odd_nibble,
	// Status towards MAC
	output reg        carrier_sense,
	output reg        collision,
	// Management control word from software and sampled data bit back
	input  wire [2:0] mgmt_ctrl,
	output reg        mgmt_data_in,
	// PHY pins
	input  wire       tx_clk,
	output reg        tx_en,
	output reg  [3:0] txd,
	input  wire       rx_clk,
	input  wire       rx_dv,
	input  wire [3:0] rxd,
	input  wire       crs,
	input  wire       col,
	output reg        mdc,
	input  wire       mdio_in,
	output reg        mdio_out,
	output reg        mdio_oe
);
	// ----------------------------------------
	// Synchronise every pin input
	// ----------------------------------------
	// Pin order in the synchroniser bank, high bit first
	wire [9:0] pin_bundle = {tx_clk, rx_clk, rx_dv, rxd, crs, col, mdio_in};
	wire [9:0] sync_q;

	pin_sync #(
		.WIDTH(10)
	) u_sync (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.pin       (pin_bundle),
		.pin_sync_q(sync_q)
	);

	wire       tx_clk_s = sync_q[9];
	wire       rx_clk_s = sync_q[8];
	wire       rx_dv_s  = sync_q[7];
	wire [3:0] rxd_s    = sync_q[6:3];
	wire       crs_s    = sync_q[2];
	wire       col_s    = sync_q[1];
	wire       mdio_s   = sync_q[0];

	// ----------------------------------------
	// Link clock edges
	// ----------------------------------------
	// A link clock that is high when reset ends would otherwise look like a
	// fresh rise before the delay flops hold a real sample
	reg [1:0] settle;
	wire      edges_armed = (settle == 2'h3);

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			settle <= 2'h0;
		end else if (!edges_armed) begin
			settle <= settle + 2'h1;
		end
	end

	reg tx_clk_d;
	reg rx_clk_d;

	// Rises are seen two ref_clk cycles after the pin moves
	wire tx_rise = tx_clk_s & ~tx_clk_d & edges_armed;
	wire rx_rise = rx_clk_s & ~rx_clk_d & edges_armed;

	// ----------------------------------------
	// Transmit path
	// ----------------------------------------
	localparam TX_IDLE = 3'b001;
	localparam TX_LOW  = 3'b010;
	localparam TX_HIGH = 3'b100;

	reg [2:0] tx_state;
	reg [3:0] tx_hi_nib;

	// Nibbles change about three ref_clk cycles after tx_clk rises, a whole link
	// period less those cycles before the PHY samples them on the next rise
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_clk_d      <= 1'b0;
			tx_state      <= TX_IDLE;
			tx_en         <= 1'b0;
			txd           <= 4'h0;
			tx_hi_nib     <= 4'h0;
			tx_byte_ready <= 1'b0;
		end else begin
			tx_clk_d      <= tx_clk_s;
			tx_byte_ready <= 1'b0;
			if (tx_rise) begin
				case (tx_state)
				TX_IDLE, TX_HIGH: begin
					if (tx_state == TX_HIGH) begin
						txd   <= tx_hi_nib;
						tx_en <= 1'b1;
						tx_state <= TX_LOW;
					end else if (tx_byte_valid) begin
						txd           <= tx_byte[3:0];
						tx_hi_nib     <= tx_byte[7:4];
						tx_en         <= 1'b1;
						tx_byte_ready <= 1'b1;
						tx_state      <= TX_HIGH;
					end else begin
						tx_en <= 1'b0;
						txd   <= 4'h0;
					end
				end
				TX_LOW: begin
					if (tx_byte_valid) begin
						txd           <= tx_byte[3:0];
						tx_hi_nib     <= tx_byte[7:4];
						tx_byte_ready <= 1'b1;
						tx_state      <= TX_HIGH;
					end else begin
						// No byte at a byte boundary ends the frame
						tx_en    <= 1'b0;
						txd      <= 4'h0;
						tx_state <= TX_IDLE;
					end
				end
				default: begin
					tx_en    <= 1'b0;
					tx_state <= TX_IDLE;
				end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Receive path
	// ----------------------------------------
	reg       rx_have_low;
	reg [3:0] rx_low_nib;

	// rx_dv and rxd ride the same synchroniser as rx_clk, so one sample
	// holds a matched set of clock, valid and data
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_clk_d        <= 1'b0;
			rx_have_low     <= 1'b0;
			rx_low_nib      <= 4'h0;
			rx_byte         <= 8'h00;
			rx_byte_valid   <= 1'b0;
			rx_frame_active <= 1'b0;
			rx_odd_nibble   <= 1'b0;
		end else begin
			rx_clk_d      <= rx_clk_s;
			rx_byte_valid <= 1'b0;
			rx_odd_nibble <= 1'b0;
			if (rx_rise) begin
				rx_frame_active <= rx_dv_s;
				if (rx_dv_s) begin
					if (rx_have_low) begin
						rx_byte       <= {rxd_s, rx_low_nib};
						rx_byte_valid <= 1'b1;
						rx_have_low   <= 1'b0;
					end else begin
						rx_low_nib  <= rxd_s;
						rx_have_low <= 1'b1;
					end
				end else begin
					// Unpaired last nibble is dropped and flagged
					rx_odd_nibble <= rx_have_low;
					rx_have_low   <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// Carrier and collision
	// ----------------------------------------
	// Re-timed only; the MAC decides what a collision means
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			carrier_sense <= 1'b0;
			collision     <= 1'b0;
		end else begin
			carrier_sense <= crs_s;
			collision     <= col_s;
		end
	end

	// ----------------------------------------
	// Management pins
	// ----------------------------------------
	// Software makes every mdc edge itself and must keep it slow enough;
	// there is no divider here
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mdc          <= 1'b0;
			mdio_out     <= 1'b0;
			mdio_oe      <= 1'b0;
			mgmt_data_in <= 1'b0;
		end else begin
			mdc          <= mgmt_ctrl[`MGMT_CLK_BIT];
			mdio_out     <= mgmt_ctrl[`MGMT_OUT_BIT];
			mdio_oe      <= mgmt_ctrl[`MGMT_DIR_BIT];
			mgmt_data_in <= mdio_s;
		end
	end
endmodule // mii_port

// File: sim/phy_model.sv
// PHY stand-in: free-running link clocks, nibble capture and receive frames
// Assumes the block samples both link clocks from ref_clk
`timescale 1ns/1ps
module phy_model (
	output logic       tx_clk = 0,
	output logic       rx_clk = 0,
	output logic       rx_dv = 0,
	output logic [3:0] rxd = 4'hf,
	input  wire        tx_en,
	input  wire  [3:0] txd
);
	logic [3:0] lo;
	logic       h = 0;
	byte        q[$];
	always #80 tx_clk = ~tx_clk;
	always #80 rx_clk = ~rx_clk;
	always @(posedge tx_clk) if (tx_en) begin
		if (h) q.push_back({txd, lo});
		else lo = txd;
		h = !h;
	end
	task send(input logic [7:0] b);
		@(negedge rx_clk);
		rx_dv = 1;
		rxd = b[3:0];
		@(negedge rx_clk);
		rxd = b[7:4];
	endtask
	// Lone nibble with valid still high
	task nib(input logic [3:0] n);
		@(negedge rx_clk);
		rxd = n;
	endtask
	// Pull-ups leave the data lines high when idle
	task stop;
		@(negedge rx_clk);
		rx_dv = 0;
		rxd = 4'hf;
	endtask
endmodule // phy_model

// File: sim/mii_port_properties.sv
// Port assertions for mii_port
// Assumes one ref_clk domain; bound below
`timescale 1ns/1ps
module mii_port_properties (
	input wire logic       ref_clk, rst_n, tx_clk, tx_en, tx_byte_ready,
	input wire logic [3:0] txd,
	input wire logic [7:0] tx_byte,
	input wire logic       rx_byte_valid, crs, col, carrier_sense, collision,
	input wire logic [2:0] mgmt_ctrl,
	input wire logic       mdc, mdio_out, mdio_oe, mdio_in, mgmt_data_in
);
	logic [6:0] th;
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n) th <= 7'h00;
		else th <= {th[5:0], tx_clk};
	wire tr = |(th[5:0] & ~th[6:1]);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence one_pulse;
		rx_byte_valid ##1 !rx_byte_valid;
	endsequence
	en_edge_a: assert property ($changed(tx_en) |-> tr)
		else $error("tx_en moved off a tx_clk rise");
	txd_edge_a: assert property ($changed(txd) |-> tr)
		else $error("txd moved off a tx_clk rise");
	low_first_a: assert property (tx_byte_ready |-> tx_en && txd == tx_byte[3:0])
		else $error("low nibble not first");
	rx_pulse_a: assert property (rx_byte_valid |-> one_pulse)
		else $error("rx_byte_valid longer than one cycle");
	crs_sync_a: assert property ($rose(crs) |-> ##3 carrier_sense)
		else $error("carrier_sense late");
	col_sync_a: assert property ($rose(col) |-> ##[2:3] collision)
		else $error("collision late");
	mdc_reg_a: assert property ($changed(mgmt_ctrl[0]) |=> mdc == $past(mgmt_ctrl[0]))
		else $error("mdc not following control bit");
	mdio_drv_a: assert property ({mdio_oe, mdio_out} == $past(mgmt_ctrl[2:1]))
		else $error("mdio drive wrong");
	mdio_in_a: assert property ($rose(mdio_in) |-> ##3 mgmt_data_in)
		else $error("mgmt_data_in late");
endmodule // mii_port_properties
bind mii_port mii_port_properties u_props (.*);

// File: sim/mii_port_tb.sv
// Testbench for mii_port
// Assumes phy_model on the link side
`timescale 1ns/1ps
module mii_port_tb;
	logic       ref_clk = 0, rst_n = 0, tx_byte_valid = 0, crs = 0, col = 0, phy_md = 1;
	logic [7:0] tx_byte = 8'h00;
	logic [2:0] mgmt_ctrl = 3'h0;
	wire  [7:0] rx_byte;
	wire  [3:0] txd, rxd;
	wire        tx_byte_ready, rx_byte_valid, rx_frame_active, rx_odd_nibble, carrier_sense;
	wire        collision, mgmt_data_in, tx_clk, tx_en, rx_clk, rx_dv, mdc, mdio_out, mdio_oe;
	wire        mdio_in = mdio_oe ? mdio_out : phy_md;
	int         miscompares = 0, compares = 0, cyc = 0, odd_cnt = 0;
	byte        rq[$];
	mii_port u_dut (.*);
	phy_model u_phy (.*);
	always #10 ref_clk = ~ref_clk;
	always @(negedge ref_clk) begin
		if (rx_byte_valid) rq.push_back(rx_byte);
		if (rx_odd_nibble) odd_cnt++;
		if (++cyc == 5000) begin
			miscompares++;
			end_of_test;
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [7:0] s, e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %0t %h %h", $time, s, e);
		end
	endtask
	task end_of_test;
		if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task wt_rdy;
		for (int i = 0; i < 99 && tx_byte_ready !== 1; i++) @(negedge ref_clk);
	endtask
	task t_tx;
		tx_byte = 8'ha5;
		tx_byte_valid = 1;
		wt_rdy;
		@(negedge ref_clk);
		tx_byte = 8'h3c;
		wt_rdy;
		@(negedge ref_clk);
		tx_byte_valid = 0;
		for (int i = 0; i < 99 && tx_en !== 0; i++) @(negedge ref_clk);
		chk(u_phy.q.size(), 2);
		chk(u_phy.q[0], 8'ha5);
		chk(u_phy.q[1], 8'h3c);
	endtask
	task t_rx;
		u_phy.send(8'h96);
		u_phy.send(8'h1e);
		chk(rx_frame_active, 1);
		u_phy.nib(4'h7);
		u_phy.stop;
		repeat (20) @(negedge ref_clk);
		chk(rq.size(), 2);
		chk(rq[0], 8'h96);
		chk(rq[1], 8'h1e);
		chk(odd_cnt, 1);
		chk(rx_frame_active, 0);
	endtask
	task t_mg;
		for (int v = 0; v < 8; v++) begin
			mgmt_ctrl = v[2:0];
			repeat (11) @(negedge ref_clk);
			chk(mdc, v[0]);
			chk({mdio_oe, mdio_out}, v[2:1]);
			chk(mgmt_data_in, v[2] ? v[1] : 1'b1);
		end
		mgmt_ctrl = 3'h0;
		phy_md = 0;
		repeat (6) @(negedge ref_clk);
		chk(mgmt_data_in, 0);
	endtask
	task t_cs;
		crs = 1;
		col = 1;
		repeat (5) @(negedge ref_clk);
		chk({carrier_sense, collision}, 2'h3);
		crs = 0;
		col = 0;
		repeat (5) @(negedge ref_clk);
		chk({carrier_sense, collision}, 2'h0);
	endtask
	initial begin
		repeat (16) @(negedge ref_clk);
		rst_n = 1;
		t_tx;
		t_rx;
		t_mg;
		t_cs;
		end_of_test;
	end
endmodule // mii_port_tb
